// ===== rtl/sct_defines.vh
`ifndef SCT_DEFINES_VH
`define SCT_DEFINES_VH

// Register byte offsets
`define SCT_OFF_CTRL      8'h00
`define SCT_OFF_SW_EVENT  8'h14
`define SCT_OFF_CH_MODE   8'h18
`define SCT_OFF_POL_EN    8'h20
`define SCT_OFF_COUNT     8'h24
`define SCT_OFF_DIVIDER   8'h28
`define SCT_OFF_WRAP      8'h2c
`define SCT_OFF_MATCH_CAP 8'h34
`define SCT_OFF_PROTECT   8'h44
`define SCT_OFF_IN_SEL    8'h50
`define SCT_OFF_WR_FILT   8'hfc

// Field positions
`define SCT_CTRL_RUN_BIT       0
`define SCT_SW_UPDATE_BIT      0
`define SCT_MODE_LSB           0
`define SCT_MODE_MSB           1
`define SCT_CMP_SHADOW_BIT     3
`define SCT_ENABLE_BIT         0
`define SCT_POLARITY_BIT       1
`define SCT_COMP_POLARITY_BIT  3
`define SCT_PROTECTION_LEVEL_LSB           8
`define SCT_PROTECTION_LEVEL_MSB           9
`define SCT_IN_SEL_LSB         0
`define SCT_IN_SEL_MSB         1
`define SCT_WR_FILT_BIT        1

// Field codes
`define SCT_MODE_OUTPUT  2'b00
`define SCT_MODE_INPUT   2'b01
`define SCT_SRC_PIN      2'b00
`define SCT_SRC_RTC      2'b01
`define SCT_SRC_XTAL32   2'b10
`define SCT_SRC_CKOUT    2'b11

// Reset values
`define SCT_RST_WORD  32'h00000000
`define SCT_RST_HALF  16'h0000

`endif

// ===== rtl/sct_edge_detect.v
`timescale 1ns/10ps
`include "sct_defines.vh"

module sct_edge_detect (
	input wire clk_i,
	input wire rst_i,
	input wire sig_i,
	input wire polarity_i,
	input wire comp_polarity_i,
	output wire event_o
);
	reg prev_q;
	wire rise;
	wire fall;

	assign rise = sig_i & ~prev_q;
	assign fall = ~sig_i & prev_q;

	// Reserved code 10 never yields an event
	assign event_o = ({comp_polarity_i, polarity_i} == 2'b00) ? rise :
		({comp_polarity_i, polarity_i} == 2'b01) ? fall :
		({comp_polarity_i, polarity_i} == 2'b11) ? (rise | fall) : 1'b0;

	always @(posedge clk_i) begin
		if (rst_i) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= sig_i;
		end
	end
endmodule // sct_edge_detect

// ===== rtl/sct_prescaler.v
`timescale 1ns/10ps
`include "sct_defines.vh"

module sct_prescaler #(
	parameter WIDTH = 16
) (
	input wire clk_i,
	input wire rst_i,
	input wire run_i,
	input wire div_wr_i,
	input wire [WIDTH-1:0] div_wdata_i,
	input wire update_i,
	input wire sw_clear_i,
	output wire [WIDTH-1:0] div_value_o,
	output wire tick_o
);
	reg [WIDTH-1:0] div_q;
	reg [WIDTH-1:0] shadow_q;
	reg [WIDTH-1:0] count_q;

	assign div_value_o = div_q;
	// One tick every shadow+1 kernel clocks
	assign tick_o = run_i & (count_q == shadow_q);

	always @(posedge clk_i) begin
		if (rst_i) begin
			div_q <= {WIDTH{1'b0}};
			shadow_q <= {WIDTH{1'b0}};
			count_q <= {WIDTH{1'b0}};
		end else begin
			if (div_wr_i) begin
				div_q <= div_wdata_i;
			end
			// A new divider only acts once copied at an update event
			if (update_i) begin
				shadow_q <= div_q;
			end
			if (sw_clear_i) begin
				count_q <= {WIDTH{1'b0}};
			end else if (tick_o) begin
				count_q <= {WIDTH{1'b0}};
			end else if (run_i) begin
				count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule // sct_prescaler

// ===== rtl/sct_timer.v
// Chosen here: register access over Wishbone.
`timescale 1ns/10ps
`include "sct_defines.vh"

// What this block does
// - Complementary polarity bit 3 in output mode: 0 active high, 1 active low.
// - Polarity bits ignore writes while protection level is 11 or 10.
// - Polarity bit 1 in output mode: 0 high active, 1 low active.
// - Input edge pair: 00 rising, 01 falling, 10 reserved, 11 both edges.
// - Enable bit 0 turns the channel capture/compare function off or on.
// - Counter reads current count; software write replaces the running count.
// - Counter clock is kernel clock divided by divider value plus one.
// - New divider value acts only after copy to shadow at update event.
// - A 16-bit wrap limit sets where the counter wraps.
// - In input mode the channel value holds last capture and is read-only.
// - Output mode compare value; with shadow enabled it refreshes at update events.
// - Input source select: pin, RTC clock, crystal/32, selected clock output.
// - With write filter on, a channel value write equal to the held value is discarded.
// - Mode field 00 output, 01 input from the selected source signal, unfiltered, others reserved.
// - Software update request clears counter and prescaler internal count.

module sct_timer #(
	parameter CNT_W = 16
) (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire ch0_pin_i,
	input wire rtc_clock_i,
	input wire high_speed_crystal_div32_i,
	input wire selected_clock_output_i,
	output reg ch0_o,
	output reg ch0n_o
);
	function hit;
		input [7:0] adr;
		input [7:0] off;
		begin
			hit = (adr[7:2] == off[7:2]);
		end
	endfunction

	reg run_q;
	reg [1:0] mode_q;
	reg cmp_shadow_en_q;
	reg channel_enable_q;
	reg channel_polarity_q;
	reg complementary_polarity_q;
	reg [1:0] protection_level_q;
	reg [CNT_W-1:0] count_value_q;
	reg [CNT_W-1:0] count_value_d;
	reg [CNT_W-1:0] wrap_limit_q;
	reg [CNT_W-1:0] match_capture_q;
	reg [CNT_W-1:0] cmp_active_q;
	reg [1:0] input_source_select_q;
	reg same_value_write_filter_q;
	reg [31:0] rdata;
	reg src_sig;

	wire access;
	wire wr;
	wire rd_unused;
	wire sw_update;
	wire tick;
	wire overflow;
	wire update;
	wire capture_event;
	wire is_input;
	wire is_output;
	wire pol_locked;
	wire cv_wr_ok;
	wire [CNT_W-1:0] div_value;
	wire [CNT_W-1:0] cmp_value;
	wire cmp_ref;
	wire wr_ctrl;
	wire wr_mode;
	wire wr_pol;
	wire wr_count;
	wire wr_div;
	wire wr_wrap;
	wire wr_cv;
	wire wr_protection_level;
	wire wr_in_sel;
	wire wr_filt;

	// Act on the edge at which ack rises; ack lasts one cycle
	assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = access & wb_we_i;
	assign rd_unused = |wb_sel_i; // Byte lanes ignored: every access is a full word

	// One write strobe per register, shared by every process that stores it
	assign wr_ctrl = wr & hit(wb_adr_i, `SCT_OFF_CTRL);
	assign wr_mode = wr & hit(wb_adr_i, `SCT_OFF_CH_MODE);
	assign wr_pol = wr & hit(wb_adr_i, `SCT_OFF_POL_EN);
	assign wr_count = wr & hit(wb_adr_i, `SCT_OFF_COUNT);
	assign wr_div = wr & hit(wb_adr_i, `SCT_OFF_DIVIDER);
	assign wr_wrap = wr & hit(wb_adr_i, `SCT_OFF_WRAP);
	assign wr_cv = wr & hit(wb_adr_i, `SCT_OFF_MATCH_CAP);
	assign wr_protection_level = wr & hit(wb_adr_i, `SCT_OFF_PROTECT);
	assign wr_in_sel = wr & hit(wb_adr_i, `SCT_OFF_IN_SEL);
	assign wr_filt = wr & hit(wb_adr_i, `SCT_OFF_WR_FILT);

	// The update request is a strobe and never stored, so its register reads back zero
	assign sw_update = wr & hit(wb_adr_i, `SCT_OFF_SW_EVENT) & wb_dat_i[`SCT_SW_UPDATE_BIT];
	// Overflow is judged on a tick only, so a stopped counter never wraps
	assign overflow = tick & (count_value_q == wrap_limit_q);
	assign update = overflow | sw_update;
	assign is_input = (mode_q == `SCT_MODE_INPUT);
	assign is_output = (mode_q == `SCT_MODE_OUTPUT);
	assign pol_locked = protection_level_q[1]; // Levels 10 and 11 lock polarity

	// Filter drops a write that would not change the value
	assign cv_wr_ok = is_output &
		~(same_value_write_filter_q & (wb_dat_i[CNT_W-1:0] == match_capture_q));

	// Without shadow the preload acts at once; with it, only at update events
	assign cmp_value = cmp_shadow_en_q ? cmp_active_q : match_capture_q;
	assign cmp_ref = (count_value_q < cmp_value);

	// Sources are taken as synchronous to the kernel clock; there is no filter stage
	always @* begin
		case (input_source_select_q)
			`SCT_SRC_PIN: src_sig = ch0_pin_i;
			`SCT_SRC_RTC: src_sig = rtc_clock_i;
			`SCT_SRC_XTAL32: src_sig = high_speed_crystal_div32_i;
			`SCT_SRC_CKOUT: src_sig = selected_clock_output_i;
			default: src_sig = ch0_pin_i;
		endcase
	end

	// The divider preload reads back at once; only its shadow waits for an update event
	sct_prescaler #(
		.WIDTH(CNT_W)
	) u_prescaler (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.run_i(run_q),
		.div_wr_i(wr_div),
		.div_wdata_i(wb_dat_i[CNT_W-1:0]),
		.update_i(update),
		.sw_clear_i(sw_update),
		.div_value_o(div_value),
		.tick_o(tick)
	);

	sct_edge_detect u_edge (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.sig_i(src_sig),
		.polarity_i(channel_polarity_q),
		.comp_polarity_i(complementary_polarity_q),
		.event_o(capture_event)
	);

	// A software write to the count beats both the update clear and the tick
	always @* begin
		count_value_d = count_value_q;
		if (wr_count) begin
			count_value_d = wb_dat_i[CNT_W-1:0];
		end else if (sw_update) begin
			count_value_d = {CNT_W{1'b0}};
		end else if (overflow) begin
			count_value_d = {CNT_W{1'b0}};
		end else if (tick) begin
			count_value_d = count_value_q + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// Reserved bits and unmapped offsets read as zero
	always @* begin
		rdata = 32'h00000000;
		if (hit(wb_adr_i, `SCT_OFF_CTRL)) begin
			rdata[`SCT_CTRL_RUN_BIT] = run_q;
		end else if (hit(wb_adr_i, `SCT_OFF_CH_MODE)) begin
			rdata[`SCT_MODE_MSB:`SCT_MODE_LSB] = mode_q;
			rdata[`SCT_CMP_SHADOW_BIT] = cmp_shadow_en_q;
		end else if (hit(wb_adr_i, `SCT_OFF_POL_EN)) begin
			rdata[`SCT_ENABLE_BIT] = channel_enable_q;
			rdata[`SCT_POLARITY_BIT] = channel_polarity_q;
			rdata[`SCT_COMP_POLARITY_BIT] = complementary_polarity_q;
		end else if (hit(wb_adr_i, `SCT_OFF_COUNT)) begin
			rdata[CNT_W-1:0] = count_value_q;
		end else if (hit(wb_adr_i, `SCT_OFF_DIVIDER)) begin
			rdata[CNT_W-1:0] = div_value;
		end else if (hit(wb_adr_i, `SCT_OFF_WRAP)) begin
			rdata[CNT_W-1:0] = wrap_limit_q;
		end else if (hit(wb_adr_i, `SCT_OFF_MATCH_CAP)) begin
			rdata[CNT_W-1:0] = match_capture_q;
		end else if (hit(wb_adr_i, `SCT_OFF_PROTECT)) begin
			rdata[`SCT_PROTECTION_LEVEL_MSB:`SCT_PROTECTION_LEVEL_LSB] = protection_level_q;
		end else if (hit(wb_adr_i, `SCT_OFF_IN_SEL)) begin
			rdata[`SCT_IN_SEL_MSB:`SCT_IN_SEL_LSB] = input_source_select_q;
		end else if (hit(wb_adr_i, `SCT_OFF_WR_FILT)) begin
			rdata[`SCT_WR_FILT_BIT] = same_value_write_filter_q;
		end
	end

	// Read data is latched only on reads, so it holds between accesses
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= `SCT_RST_WORD;
		end else begin
			wb_ack_o <= access;
			if (access & ~wb_we_i) begin
				wb_dat_o <= rdata;
			end
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			run_q <= 1'b0;
			mode_q <= `SCT_MODE_OUTPUT;
			cmp_shadow_en_q <= 1'b0;
			channel_enable_q <= 1'b0;
			channel_polarity_q <= 1'b0;
			complementary_polarity_q <= 1'b0;
			protection_level_q <= 2'b00;
			wrap_limit_q <= `SCT_RST_HALF;
			input_source_select_q <= `SCT_SRC_PIN;
			same_value_write_filter_q <= 1'b0;
		end else if (wr) begin
			if (wr_ctrl) begin
				run_q <= wb_dat_i[`SCT_CTRL_RUN_BIT];
			end
			if (wr_mode) begin
				// Mode may only change while the channel is off
				if (~channel_enable_q) begin
					mode_q <= wb_dat_i[`SCT_MODE_MSB:`SCT_MODE_LSB];
				end
				cmp_shadow_en_q <= wb_dat_i[`SCT_CMP_SHADOW_BIT];
			end
			if (wr_pol) begin
				channel_enable_q <= wb_dat_i[`SCT_ENABLE_BIT];
				if (~pol_locked) begin
					channel_polarity_q <= wb_dat_i[`SCT_POLARITY_BIT];
					complementary_polarity_q <= wb_dat_i[`SCT_COMP_POLARITY_BIT];
				end
			end
			if (wr_protection_level) begin
				protection_level_q <= wb_dat_i[`SCT_PROTECTION_LEVEL_MSB:`SCT_PROTECTION_LEVEL_LSB];
			end
			if (wr_wrap) begin
				wrap_limit_q <= wb_dat_i[CNT_W-1:0];
			end
			if (wr_in_sel) begin
				input_source_select_q <= wb_dat_i[`SCT_IN_SEL_MSB:`SCT_IN_SEL_LSB];
			end
			if (wr_filt) begin
				same_value_write_filter_q <= wb_dat_i[`SCT_WR_FILT_BIT];
			end
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			count_value_q <= `SCT_RST_HALF;
		end else begin
			count_value_q <= count_value_d;
		end
	end

	// Capture and software write never meet: input mode makes the value read-only
	always @(posedge clk_i) begin
		if (rst_i) begin
			match_capture_q <= `SCT_RST_HALF;
			cmp_active_q <= `SCT_RST_HALF;
		end else begin
			if (is_input & channel_enable_q & capture_event) begin
				match_capture_q <= count_value_q;
			end else if (wr_cv & cv_wr_ok) begin
				match_capture_q <= wb_dat_i[CNT_W-1:0];
			end
			if (update) begin
				cmp_active_q <= match_capture_q;
			end
		end
	end

	// Outputs idle low while the channel is off or in input mode
	// The complementary output rests on the inverse of the compare result
	always @(posedge clk_i) begin
		if (rst_i) begin
			ch0_o <= 1'b0;
			ch0n_o <= 1'b0;
		end else if (is_output & channel_enable_q) begin
			ch0_o <= cmp_ref ^ channel_polarity_q;
			ch0n_o <= ~cmp_ref ^ complementary_polarity_q;
		end else begin
			ch0_o <= 1'b0;
			ch0n_o <= 1'b0;
		end
	end
endmodule // sct_timer

// ===== tb/sct_checker.sv
`timescale 1ns/10ps
module sct_checker (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire ch0_o,
	input wire ch0n_o
);
	wire take;
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	AST_ACK_NEXT: assert property (take |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	AST_ACK_CAUSE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	AST_UPPER_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	AST_SWEVT_ZERO: assert property (take && !wb_we_i && wb_adr_i[7:2] == 6'h05 |=> wb_dat_o == 32'h0)
		else $error("update request register read not zero");
	AST_HOLE_ZERO: assert property (take && !wb_we_i && wb_adr_i[7:2] == 6'h10 |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	AST_DAT_HOLD: assert property (!(take && !wb_we_i) |=> $stable(wb_dat_o))
		else $error("read data moved without a read");
	AST_OUT_IDLE: assert property ($fell(rst_i) |-> (!ch0_o && !ch0n_o) [*2])
		else $error("outputs active right after reset");
	COV_WRITE: cover property (take && wb_we_i);
	COV_READ: cover property (take && !wb_we_i);
	COV_OUT: cover property ($rose(ch0_o));
endmodule // sct_checker

bind sct_timer sct_checker sct_checker_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .ch0_o(ch0_o), .ch0n_o(ch0n_o));

// ===== tb/sct_pin_model.sv
`timescale 1ns/10ps
module sct_pin_model (
	input wire clk_i,
	input wire ch0_o,
	input wire ch0n_o,
	output reg [3:0] src_o
);
	// Pin and clock sources stand still low between stimuli
	initial src_o = 4'h0;
	task drive(input [1:0] k, input v);
		begin
			@(posedge clk_i);
			src_o[k] <= v;
		end
	endtask
endmodule // sct_pin_model

// ===== tb/sct_timer_bench.sv
`timescale 1ns/10ps
module sct_timer_bench;
	reg clk_i = 1'b0;
	reg rst_i = 1'b1;
	reg wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	reg [7:0] wb_adr_i = 8'h00;
	reg [31:0] wb_dat_i = 32'h0;
	wire [31:0] wb_dat_o;
	wire wb_ack_o, ch0_o, ch0n_o;
	wire [3:0] src;
	integer n_errors = 0, tests_run = 0, i;
	reg [31:0] q, e;
	reg [87:0] offs = 88'hfc_50_44_34_2c_28_24_20_18_14_00;

	initial forever #50 clk_i = ~clk_i;

	sct_timer sct_timer_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .ch0_pin_i(src[0]), .rtc_clock_i(src[1]), .high_speed_crystal_div32_i(src[2]),
		.selected_clock_output_i(src[3]), .ch0_o(ch0_o), .ch0n_o(ch0n_o));
	sct_pin_model sct_pin_model_inst (.clk_i(clk_i), .ch0_o(ch0_o), .ch0n_o(ch0n_o), .src_o(src));

	task tally_and_finish;
		begin
			if (n_errors == 0 && tests_run > 0) begin
				$display("DONE - PASS");
			end else begin
				$display("DONE - FAIL");
			end
			$finish;
		end
	endtask
	task chk(input string nm, input [31:0] seen, input [31:0] exp);
		begin
			tests_run++;
			if (seen !== exp) begin
				$display("BAD %0s exp %h seen %h", nm, exp, seen);
				n_errors++;
			end
		end
	endtask
	task xfer(input [7:0] a, input w, input [31:0] d);
		begin
			@(posedge clk_i);
			wb_cyc_i <= 1'b1;
			wb_stb_i <= 1'b1;
			wb_we_i <= w;
			wb_adr_i <= a;
			wb_dat_i <= d;
			// Wait for ack however long it takes; only the watchdog ends a hang
			do begin
				@(posedge clk_i);
			end while (wb_ack_o !== 1'b1);
			q = wb_dat_o;
			wb_cyc_i <= 1'b0;
			wb_stb_i <= 1'b0;
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		xfer(a, 1'b1, d);
	endtask
	task rc(input string nm, input [7:0] a, input [31:0] exp);
		begin
			xfer(a, 1'b0, 32'h0);
			chk(nm, q, exp);
		end
	endtask
	// Tick phase is not pinned by the bus timing, so counts are checked as a window
	task rng(input string nm, input [31:0] lo, input [31:0] hi);
		begin
			xfer(8'h24, 1'b0, 32'h0);
			chk(nm, {31'h0, q >= lo && q <= hi}, 32'h1);
		end
	endtask
	task run_for_100;
		begin
			wr(8'h00, 32'h1);
			repeat (100) @(posedge clk_i);
			wr(8'h00, 32'h0);
		end
	endtask

	initial begin
		#3000000;
		n_errors++;
		tally_and_finish;
	end

	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		for (i = 0; i < 11; i++) rc("reset", offs[8*i +: 8], 32'h0);
		wr(8'h40, 32'h1234);
		rc("hole", 8'h40, 32'h0);
		wr(8'hfc, 32'h2);
		rc("filter", 8'hfc, 32'h2);
		wr(8'h24, 32'h1234);
		rc("count", 8'h24, 32'h1234);
		wr(8'h2c, 32'hffff);
		wr(8'h28, 32'h3);
		rc("divider", 8'h28, 32'h3);
		wr(8'h24, 32'h0);
		run_for_100;
		rng("unshadowed", 100, 106);
		wr(8'h14, 32'h1);
		rc("cleared", 8'h24, 32'h0);
		rc("swevt", 8'h14, 32'h0);
		run_for_100;
		rng("divided", 24, 28);
		wr(8'h2c, 32'h4);
		wr(8'h14, 32'h1);
		run_for_100;
		rng("wrap", 0, 4);
		wr(8'h18, 32'h0);
		wr(8'h34, 32'h8000);
		for (i = 0; i < 4; i++) begin
			wr(8'h20, {28'h0, i[1], 1'b0, i[0], 1'b1});
			repeat (3) @(posedge clk_i);
			chk("ch0", {31'h0, ch0_o}, {31'h0, ~i[0]});
			chk("ch0n", {31'h0, ch0n_o}, {31'h0, i[1]});
		end
		wr(8'h20, 32'h0);
		repeat (3) @(posedge clk_i);
		chk("off", {30'h0, ch0_o, ch0n_o}, 32'h0);
		for (i = 3; i >= 0; i--) begin
			wr(8'h44, i << 8);
			wr(8'h20, 32'ha);
			rc("protect", 8'h20, i > 1 ? 32'h0 : 32'ha);
		end
		wr(8'h20, 32'h0);
		wr(8'h18, 32'h8);
		wr(8'h14, 32'h1);
		wr(8'h34, 32'h0);
		wr(8'h20, 32'h1);
		repeat (3) @(posedge clk_i);
		chk("shadow", {31'h0, ch0_o}, 32'h1);
		wr(8'h14, 32'h1);
		repeat (3) @(posedge clk_i);
		chk("shadow upd", {31'h0, ch0_o}, 32'h0);
		wr(8'h20, 32'h0);
		wr(8'h18, 32'h1);
		e = 32'h0;
		for (i = 0; i < 4; i++) begin
			wr(8'h20, {28'h0, i[1], 1'b0, i[0], 1'b1});
			wr(8'h24, 32'h100 + 2 * i);
			sct_pin_model_inst.drive(2'd0, 1'b1);
			repeat (2) @(posedge clk_i);
			if (i == 0 || i == 3) e = 32'h100 + 2 * i;
			rc("rise", 8'h34, e);
			wr(8'h24, 32'h101 + 2 * i);
			sct_pin_model_inst.drive(2'd0, 1'b0);
			repeat (2) @(posedge clk_i);
			if (i[0]) e = 32'h101 + 2 * i;
			rc("fall", 8'h34, e);
			wr(8'h20, 32'h0);
		end
		wr(8'h20, 32'h1);
		for (i = 0; i < 4; i++) begin
			wr(8'h50, i);
			wr(8'h24, 32'h200 + i);
			sct_pin_model_inst.drive(i[1:0], 1'b1);
			repeat (2) @(posedge clk_i);
			rc("source", 8'h34, 32'h200 + i);
			sct_pin_model_inst.drive(i[1:0], 1'b0);
		end
		wr(8'h34, 32'h5555);
		rc("read only", 8'h34, 32'h203);
		tally_and_finish;
	end
endmodule // sct_timer_bench
